// ==== rtl/pio_regs.svh ====
`ifndef PIO_REGS_SVH
`define PIO_REGS_SVH

// ==========================================================
// widths, depths and reset values
`define PIO_WORD_WIDTH   8
`define PIO_FIFO_DEPTH   4
`define PIO_STAGE_RESET  8'h00
// effective clock is taken as already high at reset so a held clock cannot fire
`define PIO_EFF_PREV_RESET 1'b1

`endif

// ==== rtl/pio_pkg.sv ====
`include "pio_regs.svh"
`default_nettype none

package pio_pkg;

    typedef logic [`PIO_WORD_WIDTH-1:0] pio_word_t;

    // board-side control pins that travel together
    typedef struct packed {
        logic clearN;
        logic loadSelectN;
        logic clockInA;
        logic clockInB;
        logic serialSetIn;
        logic serialSecondN;
    } pio_ctrl_s;

    // what the register does in a given cycle
    typedef enum logic [1:0] {
        PIO_MODE_HOLD,
        PIO_MODE_CLEAR,
        PIO_MODE_LOAD,
        PIO_MODE_SHIFT
    } pio_mode_e;

endpackage

`default_nettype wire

// ==== rtl/pio_shift_register.sv ====
`include "pio_regs.svh"
`default_nettype none

// ==========================================================
// snapshot fifo
module pio_fifo #(
    parameter int WIDTH = `PIO_WORD_WIDTH,
    parameter int DEPTH = `PIO_FIFO_DEPTH
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    output logic      [WIDTH-1:0] outData,
    output logic                  outValid,
    input  wire logic             outReady
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wrPtr_reg;
    logic [AW-1:0]    rdPtr_reg;
    logic [AW:0]      count_reg;
    logic             doPush;
    logic             doPop;
    logic [AW-1:0]    wrPtr_next;
    logic [AW-1:0]    rdPtr_next;

    // flags come from the occupancy count so full and empty never disagree
    assign inReady    = (count_reg != (AW+1)'(DEPTH));
    assign outValid   = (count_reg != '0);
    assign outData    = mem_reg[rdPtr_reg];
    assign doPush     = inValid && inReady;
    assign doPop      = outValid && outReady;
    assign wrPtr_next = (wrPtr_reg == AW'(DEPTH-1)) ? '0 : wrPtr_reg + AW'(1);
    assign rdPtr_next = (rdPtr_reg == AW'(DEPTH-1)) ? '0 : rdPtr_reg + AW'(1);

    // storage is written only on push; no reset needed on the data
    always_ff @(posedge clk) begin
        if (doPush) begin
            mem_reg[wrPtr_reg] <= inData;
        end
    end

    // pointers and occupancy
    always_ff @(posedge clk) begin
        if (srst) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (doPush) begin
                wrPtr_reg <= wrPtr_next;
            end
            if (doPop) begin
                rdPtr_reg <= rdPtr_next;
            end
            count_reg <= count_reg + (AW+1)'(doPush) - (AW+1)'(doPop);
        end
    end

    // ==========================================================
    // fifo bookkeeping checks
    // the count is the single source of both flags, so guard its arithmetic
    count_bound_a: assert property (@(posedge clk) disable iff (srst)
        count_reg <= (AW+1)'(DEPTH))
        else $error("fifo count above depth");

    // equal pointers mean empty or full, never a partly filled queue
    ptr_agree_a: assert property (@(posedge clk) disable iff (srst)
        (count_reg != '0) && (count_reg != (AW+1)'(DEPTH)) |-> wrPtr_reg != rdPtr_reg)
        else $error("fifo pointers meet while partly filled");

    // a push into an empty fifo shows its word at the head next cycle
    empty_push_a: assert property (@(posedge clk) disable iff (srst)
        doPush && !outValid |=> outValid && outData == $past(inData))
        else $error("pushed word not at fifo head");

    // without a push the queue can only shrink or stay
    no_push_a: assert property (@(posedge clk) disable iff (srst)
        !doPush |=> count_reg <= $past(count_reg))
        else $error("fifo grew without a push");
endmodule

// ==========================================================
// eight-stage parallel-load / shift-right register
module pio_shift_register #(
    parameter int FIFO_DEPTH = `PIO_FIFO_DEPTH
) (
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire pio_pkg::pio_ctrl_s ctrl,
    input  wire pio_pkg::pio_word_t wordIn,
    output var pio_pkg::pio_word_t stageOut,
    output logic                   edgeReady,
    output var pio_pkg::pio_word_t snapData,
    output logic                   snapValid,
    input  wire logic              snapReady
);
    import pio_pkg::*;

    localparam int W = `PIO_WORD_WIDTH;

    pio_word_t stage_reg;
    pio_word_t stage_next;
    pio_word_t shifted;
    logic      effPrev_reg;
    logic      effClk;
    logic      clkEdge;
    logic      edgeTaken;
    logic      firstNext;
    pio_mode_e mode;

    // ==========================================================
    // effective clock and edge detect
    // an unused input tied low leaves the other as sole clock;
    // either input high keeps the OR high so the other cannot make an edge
    assign effClk    = ctrl.clockInA | ctrl.clockInB;
    assign clkEdge   = effClk & ~effPrev_reg;
    // a full snapshot fifo stalls the register: the edge is not taken
    assign edgeTaken = clkEdge & edgeReady;

    // ==========================================================
    // serial entry and mode selection
    assign firstNext = ctrl.serialSetIn
                     ? (ctrl.serialSecondN ? 1'b1 : ~stage_reg[0])
                     : (ctrl.serialSecondN ? stage_reg[0] : 1'b0);
    assign shifted   = {stage_reg[W-2:0], firstNext};
    assign mode      = !ctrl.clearN    ? PIO_MODE_CLEAR
                     : !edgeTaken      ? PIO_MODE_HOLD
                     : ctrl.loadSelectN ? PIO_MODE_SHIFT
                     : PIO_MODE_LOAD;

    always_comb begin
        unique case (mode)
            PIO_MODE_CLEAR: stage_next = `PIO_STAGE_RESET;
            PIO_MODE_LOAD:  stage_next = wordIn;
            PIO_MODE_SHIFT: stage_next = shifted;
            PIO_MODE_HOLD:  stage_next = stage_reg;
        endcase
    end

    // ==========================================================
    // state registers
    // clear acts without waiting for an effective edge, one system clock late
    always_ff @(posedge clk) begin
        if (srst) begin
            stage_reg   <= `PIO_STAGE_RESET;
            effPrev_reg <= `PIO_EFF_PREV_RESET;
        end else begin
            stage_reg   <= stage_next;
            effPrev_reg <= effClk;
        end
    end

    assign stageOut = stage_reg;

    // ==========================================================
    // every taken edge outside a clear pushes the new word for the downstream reader
    pio_fifo #(
        .WIDTH (W),
        .DEPTH (FIFO_DEPTH)
    ) u_snap_fifo (
        .clk      (clk),
        .srst     (srst),
        .inData   (stage_next),
        .inValid  (edgeTaken && ctrl.clearN),
        .inReady  (edgeReady),
        .outData  (snapData),
        .outValid (snapValid),
        .outReady (snapReady)
    );

    // ==========================================================
    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    clear_forces_low_a: assert property (
        !ctrl.clearN |=> stageOut == 8'h00)
        else $error("clear did not force stages low");

    parallel_load_a: assert property (
        ctrl.clearN && edgeTaken && !ctrl.loadSelectN |=> stageOut == $past(wordIn))
        else $error("load did not copy word");

    shift_right_a: assert property (
        ctrl.clearN && edgeTaken && ctrl.loadSelectN
        |=> stageOut[W-1:1] == $past(stageOut[W-2:0]))
        else $error("shift did not move stages");

    serial_toggle_a: assert property (
        ctrl.clearN && edgeTaken && ctrl.loadSelectN
        && ctrl.serialSetIn && !ctrl.serialSecondN
        |=> stageOut[0] != $past(stageOut[0]))
        else $error("first stage did not toggle");

    serial_force_a: assert property (
        ctrl.clearN && edgeTaken && ctrl.loadSelectN
        && (ctrl.serialSetIn == ctrl.serialSecondN)
        |=> stageOut[0] == $past(ctrl.serialSetIn))
        else $error("first stage not forced by serial inputs");

    inhibit_hold_a: assert property (
        ctrl.clearN && (ctrl.clockInA || ctrl.clockInB) ##1
        ctrl.clearN && (ctrl.clockInA || ctrl.clockInB) |=> $stable(stageOut))
        else $error("state changed while a clock input held high");

    edge_only_a: assert property (
        ctrl.clearN && !(effClk && !$past(effClk)) |=> $stable(stageOut))
        else $error("state changed without an effective edge");

    // both pins low can never clock the register
    pins_low_a: assert property (
        ctrl.clearN && !ctrl.clockInA && !ctrl.clockInB |=> $stable(stageOut))
        else $error("state changed with both clock pins low");

    // an edge refused by a full fifo must leave the stages alone
    stall_hold_a: assert property (
        ctrl.clearN && clkEdge && !edgeReady |=> $stable(stageOut))
        else $error("stages moved on a dropped edge");

    // a clear never lands in the snapshot queue
    clear_no_push_a: assert property (
        !ctrl.clearN && !snapValid |=> !snapValid)
        else $error("clear pushed a snapshot");

    // a clear overrides a load edge in the same cycle
    clear_over_load_a: assert property (
        !ctrl.clearN && clkEdge && !ctrl.loadSelectN |=> stageOut == 8'h00)
        else $error("load edge beat the clear");

    // a load into an empty queue shows the loaded word at the head
    load_push_a: assert property (
        ctrl.clearN && edgeTaken && !ctrl.loadSelectN && !snapValid
        |=> snapValid && snapData == $past(wordIn))
        else $error("loaded word not queued");

    // keep code leaves the first stage as it was
    serial_keep_a: assert property (
        ctrl.clearN && edgeTaken && ctrl.loadSelectN
        && !ctrl.serialSetIn && ctrl.serialSecondN
        |=> stageOut[0] == $past(stageOut[0]))
        else $error("first stage not kept");

    // every taken edge outside a clear leaves at least one word queued
    push_valid_a: assert property (
        ctrl.clearN && edgeTaken |=> snapValid)
        else $error("taken edge left queue empty");

    // into an empty queue the snapshot equals the new stages
    snap_word_a: assert property (
        ctrl.clearN && edgeTaken && !snapValid |=> snapData == stageOut)
        else $error("snapshot differs from stages");

    // a waiting head word neither vanishes nor changes
    stable_head_a: assert property (
        snapValid && !snapReady |=> snapValid && $stable(snapData))
        else $error("head word changed while stalled");

    // a pop from a full queue reopens it for edges
    pop_frees_a: assert property (
        !edgeReady && snapReady |=> edgeReady)
        else $error("full queue not freed by pop");

    // a full queue is never reported empty
    full_valid_a: assert property (
        !edgeReady |-> snapValid)
        else $error("full queue reported empty");

    // reset leaves the stages cleared and the queue empty and open
    reset_state_a: assert property (
        disable iff (1'b0) srst |=> stageOut == 8'h00 && !snapValid && edgeReady)
        else $error("reset state wrong");

    load_cov_c:   cover property (ctrl.clearN && edgeTaken && !ctrl.loadSelectN);
    toggle_cov_c: cover property (ctrl.clearN && edgeTaken && ctrl.loadSelectN
                                  && ctrl.serialSetIn && !ctrl.serialSecondN);
    stall_cov_c:  cover property (clkEdge && !edgeReady);
    clear_cov_c:  cover property (!ctrl.clearN ##1 ctrl.clearN && edgeTaken);
endmodule

`default_nettype wire

// ==== dv/pio_board_model.sv ====
`default_nettype none
// ==========================================================
// board logic driving pins; idle clock pins sit low
module pio_board_model (
    input  wire logic         clk,
    output var pio_pkg::pio_ctrl_s ctrl,
    output var pio_pkg::pio_word_t wordIn
);
    timeunit 1ns;
    timeprecision 100ps;
    import pio_pkg::*;
    initial begin
        ctrl   = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
        wordIn = 8'h00;
    end
    // one edge on one pin, the other stays tied low
    task automatic pulse(input logic useB, input logic ldN, input pio_word_t w,
                         input logic j, input logic k);
        @(posedge clk) #1;
        ctrl.loadSelectN = ldN;
        ctrl.serialSetIn = j;
        ctrl.serialSecondN = k;
        wordIn = w;
        if (useB) ctrl.clockInB = 1'b1;
        else ctrl.clockInA = 1'b1;
        @(posedge clk) #1;
        ctrl.clockInA = 1'b0;
        ctrl.clockInB = 1'b0;
        @(posedge clk) #1;
    endtask
    // load w, then hold pin b high so later edges on pin a are blocked
    task automatic inhibit(input pio_word_t w);
        @(posedge clk) #1;
        ctrl.loadSelectN = 1'b0;
        wordIn = w;
        ctrl.clockInA = 1'b1;
        @(posedge clk) #1 ctrl.clockInB = 1'b1;
        @(posedge clk) #1 wordIn = ~w;
        ctrl.clockInA = 1'b0;
        @(posedge clk) #1 ctrl.clockInA = 1'b1;
        @(posedge clk) #1 ctrl.clockInA = 1'b0;
        @(posedge clk) #1 ctrl.clockInB = 1'b0;
        @(posedge clk) #1;
    endtask
endmodule
`default_nettype wire

// ==== dv/parallel_io_shift_register_tb.sv ====
`default_nettype none
// ==========================================================
// bench top
module parallel_io_shift_register_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import pio_pkg::*;
    logic      clk, srst, snapReady, edgeReady, snapValid;
    pio_ctrl_s ctrl;
    pio_word_t wordIn, stageOut, snapData;
    int        errorCnt = 0;
    int        testsRun = 0;

    pio_board_model pio_board_model_i (.clk(clk), .ctrl(ctrl), .wordIn(wordIn));
    pio_shift_register pio_shift_register_i (.clk(clk), .srst(srst), .ctrl(ctrl),
        .wordIn(wordIn), .stageOut(stageOut), .edgeReady(edgeReady),
        .snapData(snapData), .snapValid(snapValid), .snapReady(snapReady));

    task automatic chkW(input string nm, input pio_word_t exp, input pio_word_t got);
        testsRun++;
        if (got !== exp) begin
            errorCnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic chkB(input string nm, input logic exp, input logic got);
        chkW(nm, {7'h00, exp}, {7'h00, got});
    endtask
    task automatic completeRun();
        $display("checks %0d mismatches %0d", testsRun, errorCnt);
        if (errorCnt == 0 && testsRun > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // ==========================================================
    // scenarios
    // reader holds off so the queued word can be seen, then pops it
    task automatic testLoad();
        snapReady = 1'b0;
        pio_board_model_i.pulse(1'b0, 1'b0, 8'hA5, 1'b0, 1'b0);
        chkW("load", 8'hA5, stageOut);
        chkW("snapData", 8'hA5, snapData);
        chkB("snapValid", 1'b1, snapValid);
        snapReady = 1'b1;
        @(posedge clk) #1;
        chkB("popped", 1'b0, snapValid);
    endtask
    // all four serial codes, clocked on pin b
    task automatic testShift();
        pio_word_t s;
        logic      j, k, nb;
        s = 8'h81;
        pio_board_model_i.pulse(1'b1, 1'b0, s, 1'b0, 1'b0);
        for (int i = 0; i < 4; i++) begin
            j = i[1];
            k = i[0];
            nb = j ? (k ? 1'b1 : ~s[0]) : (k ? s[0] : 1'b0);
            s = {s[6:0], nb};
            pio_board_model_i.pulse(1'b1, 1'b1, 8'hFF, j, k);
            chkW("shift", s, stageOut);
        end
    endtask
    task automatic testInhibit();
        pio_board_model_i.inhibit(8'h3C);
        chkW("inhibit", 8'h3C, stageOut);
    endtask
    // clear overrides a load edge and pushes nothing
    task automatic testClear();
        @(posedge clk) #1 pio_board_model_i.ctrl.clearN = 1'b0;
        pio_board_model_i.pulse(1'b0, 1'b0, 8'hFF, 1'b1, 1'b1);
        chkW("clear", 8'h00, stageOut);
        chkB("clearPush", 1'b0, snapValid);
        pio_board_model_i.ctrl.clearN = 1'b1;
    endtask
    // reader stalls: fifo fills, fifth edge dropped, then drained
    task automatic testFull();
        snapReady = 1'b0;
        for (int i = 1; i <= 5; i++) pio_board_model_i.pulse(1'b0, 1'b0, 8'(i), 1'b0, 1'b0);
        chkB("edgeReady", 1'b0, edgeReady);
        chkW("dropped", 8'h04, stageOut);
        snapReady = 1'b1;
        for (int i = 1; i <= 4; i++) begin
            chkW("drain", 8'(i), snapData);
            @(posedge clk) #1;
        end
        chkB("empty", 1'b0, snapValid);
        chkB("edgeReady", 1'b1, edgeReady);
    endtask

    // ==========================================================
    // clock, reset, sequence and watchdog
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        srst = 1'b1;
        snapReady = 1'b1;
        repeat (6) @(posedge clk);
        #1 srst = 1'b0;
        chkW("resetStage", 8'h00, stageOut);
        testLoad();
        testShift();
        testInhibit();
        testClear();
        testFull();
        completeRun();
    end
    // about 55 cycles expected; generous margin
    initial begin
        #100000;
        errorCnt++;
        completeRun();
    end
endmodule
`default_nettype wire
